//--- dram_tzq_pkg.sv
`default_nettype none
package dram_tzq_pkg;

  // Clock and derived cycle counts
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TSI_MS = 32;
  localparam int unsigned TSI_CYCLES = TSI_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CAL_DUR_US = 1;
  localparam int unsigned CAL_DUR_CYCLES = (CAL_DUR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned APPLY_NS = 30;
  localparam int unsigned APPLY_NCK = 8;
  localparam int unsigned APPLY_NS_CYC = (APPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned APPLY_CYCLES = (APPLY_NS_CYC > APPLY_NCK) ? APPLY_NS_CYC : APPLY_NCK;
  localparam int unsigned DFLT_NS = 50;
  localparam int unsigned DFLT_NCK = 3;
  localparam int unsigned DFLT_NS_CYC = (DFLT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DFLT_CYCLES = (DFLT_NS_CYC > DFLT_NCK) ? DFLT_NS_CYC : DFLT_NCK;
  localparam int unsigned OFS_REFLECT_US = 200;
  localparam int unsigned OFS_REFLECT_CYCLES = OFS_REFLECT_US * 1000 / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] TEMP_STATUS_ADDR = 8'h00;
  localparam logic [7:0] CAL_CMD_ADDR = 8'h04;
  localparam logic [7:0] MPC_ADDR = 8'h08;
  localparam logic [7:0] CAL_STAT_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;

  // Field positions
  localparam int unsigned TS_CODE_LSB = 0;
  localparam int unsigned TS_OFS_LSB = 5;
  localparam int unsigned CAL_DFLT_BIT = 0;
  localparam int unsigned MPC_OP_LSB = 0;
  localparam int unsigned CS_STATE_LSB = 0;
  localparam int unsigned CS_RESULT_LSB = 8;
  localparam int unsigned CS_DRIVE_LSB = 16;

  // Multi-purpose command opcodes
  localparam logic [1:0] OP_CAL_BEGIN = 2'h1;
  localparam logic [1:0] OP_CAL_APPLY = 2'h2;

  // Temperature status codes and thresholds
  localparam logic [2:0] CODE_NORMAL = 3'h3;
  localparam logic [2:0] CODE_HOT = 3'h4;
  localparam logic [2:0] CODE_VHOT = 3'h6;
  localparam logic [2:0] TS_CODE_RESET = 3'h3;
  localparam int unsigned HOT_C = 85;
  localparam int unsigned VHOT_C = 105;
  localparam int unsigned MARGIN_C = 2;
  localparam int unsigned OFS_STEP_C = 5;

  // Interrupt bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_TEMP = 0;
  localparam int unsigned IRQ_CAL_DONE = 1;
  localparam int unsigned IRQ_APPLY_DONE = 2;
  localparam int unsigned IRQ_DFLT_DONE = 3;
  localparam int unsigned IRQ_CMD_ERR = 4;

  typedef enum logic [4:0] {
    CAL_IDLE  = 5'b00001,
    CAL_RUN   = 5'b00010,
    CAL_DONE  = 5'b00100,
    CAL_APPLY = 5'b01000,
    CAL_DFLT  = 5'b10000
  } cal_state_t;

endpackage
`default_nettype wire

//--- interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
  parameter int unsigned PERIOD = 640000
) (
  input wire logic pclk,    // Clock
  input wire logic presetn, // Async reset, active low
  output logic tick         // One-cycle pulse per period
);
  localparam int unsigned CW = $clog2(PERIOD);

  if (PERIOD < 2) begin : g_bad_period
    $error("interval_timer: PERIOD must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } timer_t;

  timer_t s, n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt == CW'(PERIOD - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

//--- dram_thermal_zq_cal.sv
// Operation
// - Sample temperature autonomously; status updates never more than 32 ms apart.
// - On clock enable rising, status is no older than the update interval.
// - Keep updating temperature status during self refresh with clock enable high.
// - Status code sits in bits [2:0]; code 011 only while the offset-adjusted reading is below 83 C.
// - Code changes 2 C before the controller's reconfiguration point.
// - Support calibration begin and apply, the latter loading drivers.
// - Calibration runs in background; other commands stay accepted, but apply is refused until calibration is done.
// - Default command returns impedance to default setting, within 30 percent.
// - Writing one to bit zero of calibration command register triggers default.
// - Thermal offset in bits [6:5] reflects in status within 200 us.
`timescale 1ns/1ps
`default_nettype none
module dram_thermal_zq_cal
  import dram_tzq_pkg::*;
#(
  parameter int unsigned TSI_CYCLES_P = TSI_CYCLES,
  parameter int unsigned CODE_W = 6,
  parameter logic [7:0] DEFAULT_CODE = 8'h20
) (
  input wire logic pclk,                  // Clock, 20 MHz
  input wire logic presetn,               // Async reset, active low
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB enable
  input wire logic pwrite,                // APB direction
  input wire logic [7:0] paddr,           // APB byte address
  input wire logic [31:0] pwdata,         // APB write data
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error
  input wire logic cke,                   // Clock enable pin level
  input wire logic power_down,            // Device in power-down
  input wire logic dq_busy,               // DQ bus operation pending
  input wire logic [7:0] sensed_temp,     // Sensor reading, degrees C
  input wire logic [CODE_W-1:0] cal_measure, // Calibration engine result
  output logic [2:0] temp_status,         // Current status code
  output logic [CODE_W-1:0] drive_code,   // Code applied to drivers
  output logic cal_busy,                  // Calibration running
  output logic apply_busy,                // Apply or default in progress
  output logic irq                        // Interrupt, active high level
);

  if (CODE_W < 1 || CODE_W > 8) begin : g_bad_code
    $error("dram_thermal_zq_cal: CODE_W must be 1 to 8");
  end
  if (TSI_CYCLES_P < 16) begin : g_bad_tsi
    $error("dram_thermal_zq_cal: TSI_CYCLES_P too small");
  end

  typedef struct packed {
    logic [2:0] ts_code;
    logic [1:0] ts_ofs;
    logic cap_pend;
    logic cke_q;
    cal_state_t cal_st;
    logic [7:0] cnt;
    logic [CODE_W-1:0] cal_result;
    logic [CODE_W-1:0] drive_code;
    logic cal_busy;
    logic apply_busy;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s, n;

  logic tick;
  logic setup;
  logic wr_acc;
  logic rd_block;
  logic cke_rise;
  logic cap_want;
  logic cap_now;
  logic ofs_wr;
  logic dflt_wr;
  logic begin_req;
  logic apply_req;
  logic begin_ok;
  logic apply_ok;
  logic cal_done_ev;
  logic [2:0] code_calc;
  logic [IRQ_W-1:0] ev;

  function automatic logic [2:0] temp_code(input logic [7:0] t, input logic [1:0] ofs);
    logic [9:0] eff;
    eff = {2'h0, t} + 10'(ofs) * 10'(OFS_STEP_C);
    if (eff >= 10'(VHOT_C - MARGIN_C)) begin
      temp_code = CODE_VHOT;
    end else if (eff >= 10'(HOT_C - MARGIN_C)) begin
      temp_code = CODE_HOT;
    end else begin
      temp_code = CODE_NORMAL;
    end
  endfunction

  // Runs in every power state, self refresh included
  interval_timer #(
    .PERIOD(TSI_CYCLES_P)
  ) u_tsi (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && s.pready && pwrite;
  assign rd_block = psel && !pwrite && (paddr == TEMP_STATUS_ADDR);
  assign cke_rise = cke && !s.cke_q;
  assign cap_want = tick || s.cap_pend || cke_rise;
  assign cap_now = cap_want && !rd_block;
  assign code_calc = temp_code(sensed_temp, s.ts_ofs);
  assign ofs_wr = wr_acc && (paddr == TEMP_STATUS_ADDR) && (pwdata[TS_OFS_LSB +: 2] != s.ts_ofs);
  assign dflt_wr = wr_acc && (paddr == CAL_CMD_ADDR) && pwdata[CAL_DFLT_BIT];
  assign begin_req = wr_acc && (paddr == MPC_ADDR) && (pwdata[MPC_OP_LSB +: 2] == OP_CAL_BEGIN);
  assign apply_req = wr_acc && (paddr == MPC_ADDR) && (pwdata[MPC_OP_LSB +: 2] == OP_CAL_APPLY);
  assign begin_ok = begin_req && !power_down && !dflt_wr && (s.cal_st != CAL_APPLY);
  assign apply_ok = apply_req && !dflt_wr && !power_down && !dq_busy && (s.cal_st == CAL_DONE);
  assign cal_done_ev = (s.cal_st == CAL_RUN) && (s.cnt == 8'h00) && !begin_ok && !dflt_wr;

  always_comb begin
    ev = '0;
    ev[IRQ_TEMP] = cap_now && (code_calc != s.ts_code);
    ev[IRQ_CAL_DONE] = cal_done_ev;
    ev[IRQ_APPLY_DONE] = (s.cal_st == CAL_APPLY) && (s.cnt == 8'h00) && !dflt_wr;
    ev[IRQ_DFLT_DONE] = (s.cal_st == CAL_DFLT) && (s.cnt == 8'h00) && !dflt_wr;
    ev[IRQ_CMD_ERR] = (begin_req && !begin_ok && !dflt_wr) || (apply_req && !apply_ok && !dflt_wr);
  end

  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.cke_q = cke;

    // Temperature capture, deferred while the status word is being read
    if (cap_now) begin
      n.ts_code = code_calc;
    end
    n.cap_pend = (cap_want && rd_block) || ofs_wr;

    // Register writes
    if (wr_acc && paddr == TEMP_STATUS_ADDR) begin
      n.ts_ofs = pwdata[TS_OFS_LSB +: 2];
    end
    if (wr_acc && paddr == IRQ_MASK_ADDR) begin
      n.irq_mask = pwdata[IRQ_W-1:0];
    end

    // Calibration sequencer; bus writes stay accepted throughout
    unique case (s.cal_st)
      CAL_IDLE, CAL_DONE: begin
        if (apply_ok) begin
          n.cal_st = CAL_APPLY;
          n.cnt = 8'(APPLY_CYCLES - 1);
          n.drive_code = s.cal_result;
        end
      end
      CAL_RUN: begin
        if (s.cnt == 8'h00) begin
          n.cal_st = CAL_DONE;
          n.cal_result = cal_measure;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      CAL_APPLY, CAL_DFLT: begin
        if (s.cnt == 8'h00) begin
          n.cal_st = CAL_IDLE;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
    endcase
    if (begin_ok) begin
      n.cal_st = CAL_RUN;
      n.cnt = 8'(CAL_DUR_CYCLES - 1);
    end
    if (dflt_wr) begin
      n.cal_st = CAL_DFLT;
      n.cnt = 8'(DFLT_CYCLES - 1);
      n.drive_code = DEFAULT_CODE[CODE_W-1:0];
    end
    n.cal_busy = (n.cal_st == CAL_RUN);
    n.apply_busy = (n.cal_st == CAL_APPLY) || (n.cal_st == CAL_DFLT);

    // Sticky status: new events win over a write-one clear
    if (wr_acc && paddr == IRQ_STATUS_ADDR) begin
      n.irq_stat = s.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    n.irq_stat = n.irq_stat | ev;
    n.irq = |(n.irq_stat & n.irq_mask);

    // Read data and answer prepared in the setup cycle
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = '0;
      unique case (paddr)
        TEMP_STATUS_ADDR: begin
          n.prdata[TS_CODE_LSB +: 3] = s.ts_code;
          n.prdata[TS_OFS_LSB +: 2] = s.ts_ofs;
        end
        CAL_STAT_ADDR: begin
          n.prdata[CS_STATE_LSB +: 5] = s.cal_st;
          n.prdata[CS_RESULT_LSB +: CODE_W] = s.cal_result;
          n.prdata[CS_DRIVE_LSB +: CODE_W] = s.drive_code;
        end
        IRQ_STATUS_ADDR: n.prdata[IRQ_W-1:0] = s.irq_stat;
        IRQ_MASK_ADDR: n.prdata[IRQ_W-1:0] = s.irq_mask;
        CAL_CMD_ADDR, MPC_ADDR: n.prdata = '0;
        default: n.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ts_code <= TS_CODE_RESET;
      s.cal_st <= CAL_IDLE;
      s.drive_code <= DEFAULT_CODE[CODE_W-1:0];
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign temp_status = s.ts_code;
  assign drive_code = s.drive_code;
  assign cal_busy = s.cal_busy;
  assign apply_busy = s.apply_busy;
  assign irq = s.irq;

  // Checking helpers
  localparam int CKE_LAT_MAX = 4;
  localparam int OFS_LAT_MAX = 6;
  logic [31:0] age_q;
  logic [7:0] run_len_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= '0;
      run_len_q <= '0;
    end else begin
      age_q <= cap_now ? 32'h0 : age_q + 32'h1;
      run_len_q <= (s.cal_st == CAL_RUN && !begin_ok) ? run_len_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apply_start;
    apply_ok;
  endsequence

  sequence s_quiet8;
    (!dflt_wr && !begin_req)[*8];
  endsequence

  sequence s_dflt_start;
    dflt_wr ##1 (!dflt_wr && !begin_req)[*3];
  endsequence

  AST_TSI_BOUND: assert property (age_q <= TSI_CYCLES_P + 2)
    else $error("temperature status older than update interval");

  AST_CKE_FRESH: assert property (cke_rise |-> ##[0:CKE_LAT_MAX] cap_now)
    else $error("no capture after clock enable rise");

  AST_CODE_CAPTURE: assert property (cap_now |=> temp_status == $past(code_calc))
    else $error("status code not taken from sensor");

  AST_OFS_REFLECT: assert property (ofs_wr |-> ##[1:OFS_LAT_MAX] cap_now)
    else $error("offset not reflected in status");

  AST_READ_STABLE: assert property (setup && paddr == TEMP_STATUS_ADDR && !pwrite |=>
    prdata[2:0] == $past(temp_status) && $stable(temp_status))
    else $error("status read disturbed by capture");

  AST_CAL_LEN: assert property (cal_done_ev |-> run_len_q == 8'(CAL_DUR_CYCLES - 1))
    else $error("calibration time wrong");

  AST_CAL_RESULT: assert property (cal_done_ev |=> cal_busy == 1'b0 &&
    s.cal_result == $past(cal_measure))
    else $error("calibration result not captured");

  AST_APPLY_LOAD: assert property (s_apply_start |=> apply_busy &&
    drive_code == $past(s.cal_result))
    else $error("apply did not load drivers");

  AST_APPLY_HOLD: assert property (s_apply_start ##1 s_quiet8 |-> apply_busy ##1 !apply_busy)
    else $error("apply time not eight cycles");

  AST_PD_REFUSE: assert property (begin_req && power_down && !dflt_wr |=>
    !cal_busy && s.irq_stat[IRQ_CMD_ERR])
    else $error("calibration begun in power-down");

  AST_DFLT: assert property (s_dflt_start |-> apply_busy &&
    drive_code == DEFAULT_CODE[CODE_W-1:0] ##1 !apply_busy)
    else $error("default sequence wrong");

  AST_IRQ_LEVEL: assert property (irq == |(s.irq_stat & s.irq_mask))
    else $error("interrupt level mismatch");

endmodule
`default_nettype wire

//--- ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic pclk,          // Clock
  input wire logic presetn,       // Reset, active low
  output logic psel,              // Select
  output logic penable,           // Enable
  output logic pwrite,            // Direction
  output logic [7:0] paddr,       // Byte address
  output logic [31:0] pwdata,     // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready,        // Ready
  input wire logic pslverr        // Error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'hFFFFFFFF;
  end

  // One transfer at a time; each call waits for pready before releasing the bus
  // Caller also sends refused commands: begin in power-down, apply before done or with busy DQ
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dram_tzq_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic cke, power_down, dq_busy, cal_busy, apply_busy, irq;
  logic [7:0] paddr, sensed_temp;
  logic [31:0] pwdata, prdata;
  logic [5:0] cal_measure, drive_code;
  logic [2:0] temp_status;
  int n_mismatch, checked, n, i;
  logic [7:0] temps [4] = '{8'd82, 8'd83, 8'd102, 8'd103};
  logic [2:0] codes [4] = '{CODE_NORMAL, CODE_HOT, CODE_HOT, CODE_VHOT};

  dram_thermal_zq_cal #(.TSI_CYCLES_P(64), .CODE_W(6), .DEFAULT_CODE(8'h20)) i_dram_thermal_zq_cal (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cke(cke), .power_down(power_down), .dq_busy(dq_busy), .sensed_temp(sensed_temp),
    .cal_measure(cal_measure), .temp_status(temp_status), .drive_code(drive_code),
    .cal_busy(cal_busy), .apply_busy(apply_busy), .irq(irq));

  ctrl_model i_ctrl_model (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_ctrl_model.xfer(1'b1, a, d, q, e);
    cmp({31'h0, e}, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    i_ctrl_model.xfer(1'b0, a, 32'h0, q, e);
    cmp(q, exp);
    cmp({31'h0, e}, {31'h0, experr});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Length of the next high run of cal_busy (pick 0) or apply_busy (pick 1)
  task automatic busy_len(input logic pick, output int len);
    len = 0;
    for (int k = 0; k < 60; k++) begin
      #1;
      if ((pick ? apply_busy : cal_busy) === 1'b1) len++;
      else if (len > 0) break;
      @(posedge pclk);
    end
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    cke = 1'b0;
    power_down = 1'b0;
    dq_busy = 1'b0;
    sensed_temp = 8'd40;
    cal_measure = 6'h15;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(32'(temp_status), 32'(CODE_NORMAL));
    cmp(32'(drive_code), 32'h20);
    cmp(32'(irq), 32'h0);
    rdc(CAL_STAT_ADDR, 32'h00200001, 1'b0);
    rdc(8'h18, 32'h0, 1'b1);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      sensed_temp <= temps[i];
      cke <= 1'b0;
      cyc(2);
      cke <= 1'b1;
      cyc(4);
      cmp(32'(temp_status), 32'(codes[i]));
    end
    sensed_temp <= 8'd90;
    cyc(70);
    cmp(32'(temp_status), 32'(CODE_HOT));
    rdc(TEMP_STATUS_ADDR, 32'h04, 1'b0);
    wr(TEMP_STATUS_ADDR, 32'h60);
    cyc(4);
    rdc(TEMP_STATUS_ADDR, 32'h66, 1'b0);
    wr(TEMP_STATUS_ADDR, 32'h00);
    cyc(4);
    cmp(32'(temp_status), 32'(CODE_HOT));
    rdc(IRQ_STATUS_ADDR, 32'h01, 1'b0);
    cmp(32'(irq), 32'h0);
    wr(IRQ_STATUS_ADDR, 32'h1F);
    rdc(IRQ_STATUS_ADDR, 32'h00, 1'b0);
    wr(IRQ_MASK_ADDR, 32'h1E);
    power_down <= 1'b1;
    wr(MPC_ADDR, 32'(OP_CAL_BEGIN));
    #1;
    cmp(32'(cal_busy), 32'h0);
    rdc(IRQ_STATUS_ADDR, 32'h10, 1'b0);
    cmp(32'(irq), 32'h1);
    wr(IRQ_STATUS_ADDR, 32'h10);
    power_down <= 1'b0;
    wr(MPC_ADDR, 32'(OP_CAL_BEGIN));
    busy_len(1'b0, n);
    cmp(32'(n), 32'(CAL_DUR_CYCLES));
    rdc(CAL_STAT_ADDR, 32'h00201504, 1'b0);
    rdc(IRQ_STATUS_ADDR, 32'h02, 1'b0);
    cmp(32'(irq), 32'h1);
    wr(IRQ_STATUS_ADDR, 32'h02);
    cyc(1);
    cmp(32'(irq), 32'h0);
    // Commands keep working while calibration runs; early apply is refused
    wr(MPC_ADDR, 32'(OP_CAL_BEGIN));
    rdc(TEMP_STATUS_ADDR, 32'h04, 1'b0);
    wr(MPC_ADDR, 32'(OP_CAL_APPLY));
    busy_len(1'b0, n);
    cmp(32'(n), 32'(CAL_DUR_CYCLES - 6));
    rdc(IRQ_STATUS_ADDR, 32'h12, 1'b0);
    wr(IRQ_STATUS_ADDR, 32'h12);
    dq_busy <= 1'b1;
    wr(MPC_ADDR, 32'(OP_CAL_APPLY));
    cyc(1);
    cmp(32'(drive_code), 32'h20);
    rdc(IRQ_STATUS_ADDR, 32'h10, 1'b0);
    wr(IRQ_STATUS_ADDR, 32'h10);
    dq_busy <= 1'b0;
    wr(MPC_ADDR, 32'(OP_CAL_APPLY));
    busy_len(1'b1, n);
    cmp(32'(n), 32'(APPLY_CYCLES));
    cmp(32'(drive_code), 32'h15);
    wr(CAL_CMD_ADDR, 32'h1);
    busy_len(1'b1, n);
    cmp(32'(n), 32'(DFLT_CYCLES));
    cmp(32'(drive_code), 32'h20);
    rdc(IRQ_STATUS_ADDR, 32'h0C, 1'b0);
    cmp(32'(irq), 32'h1);
    rdc(CAL_CMD_ADDR, 32'h0, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
